// *** pcc_pwm_config.sv ***
`timescale 1ns/100ps

// Function
// - polarity one: start high, low at duty
// - polarity zero: start low, high at duty
// - polarity bits writable at any time
// - absent channel bits ignore writes, read zero
// - channels 0,1,4,5: A, SA, B, SB
// - channels 2,3,6,7: B, SB, A, SA
// - prescalers divide by two to field
// - prescale and clock selects writable anytime
// - alignment bit one: center, zero: left
// - four join bits make 16-bit channels
// - even channel registers form upper byte
// - joined pair uses odd channel's pin, controls
// - output starts on source's next cycle
module pcc_pwm_config #(
	parameter int NUM_CH = 8
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	output logic      [7:0]  pwm_o
);
	import pcc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] enable_r;
	logic [7:0] polarity_r;
	logic [7:0] clk_sel_r;
	logic [7:0] prescale_r;
	logic [7:0] align_r;
	logic [7:0] control_r;
	logic [7:0] ab_sel_r;
	logic [7:0] scale_a_r;
	logic [7:0] scale_b_r;
	logic [7:0] period_r [8];
	logic [7:0] duty_r   [8];
	logic       ack_r;
	logic [7:0] rdata_r;

	logic [7:0] chan_mask;
	logic [7:0] join_mask;
	logic [5:0] idx;
	logic       access;
	logic       wr_en;
	logic [7:0] wdat;
	logic [7:0] rd_mux;

	logic [6:0] pre_cnt_r;
	logic [7:0] sa_cnt_r;
	logic [7:0] sb_cnt_r;
	logic [2:0] first_prescale_field;
	logic [2:0] second_prescale_field;
	logic [7:0] mask_a8;
	logic [7:0] mask_b8;
	logic       tick_a;
	logic       tick_b;
	logic       tick_sa;
	logic       tick_sb;

	logic [7:0] wave;

	// ----------------------------------------------------------------
	// implemented-channel masks
	// ----------------------------------------------------------------
	// bits of missing channels and pairs stay zero
	genvar m;
	generate
		for (m = 0; m < 8; m++) begin : g_mask
			assign chan_mask[m] = (m < NUM_CH);
			if (m >= JOIN_LSB) begin : g_join
				assign join_mask[m] = ((2 * (m - JOIN_LSB) + 1) < NUM_CH);
			end else begin : g_nojoin
				assign join_mask[m] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// wishbone decode
	// ----------------------------------------------------------------
	// one access per request; ack drops the cycle after it was given
	assign idx    = adr_i[7:2];
	assign access = cyc_i & stb_i & ~ack_r;
	assign wr_en  = access & we_i & sel_i[0];
	assign wdat   = dat_i[7:0];
	assign ack_o  = ack_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= access;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_r <= RST_ENABLE;
		end else if (wr_en && idx == IDX_ENABLE) begin
			enable_r <= wdat & chan_mask;
		end
	end

	// polarity, writable while running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			polarity_r <= RST_POLARITY;
		end else if (wr_en && idx == IDX_POLARITY) begin
			polarity_r <= wdat & chan_mask;
		end
	end

	// clock select bits, writable while running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_sel_r <= RST_CLK_SEL;
			ab_sel_r  <= RST_AB_SEL;
		end else if (wr_en && idx == IDX_CLK_SEL) begin
			clk_sel_r <= wdat & chan_mask;
		end else if (wr_en && idx == IDX_AB_SEL) begin
			ab_sel_r <= wdat & chan_mask;
		end
	end

	// prescaler fields, writable while running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prescale_r <= RST_PRESCALE;
		end else if (wr_en && idx == IDX_PRESCALE) begin
			prescale_r <= wdat & PRESCALE_MASK;
		end
	end

	// alignment bits; kept stable by software while enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			align_r <= RST_ALIGN;
		end else if (wr_en && idx == IDX_ALIGN) begin
			align_r <= wdat & chan_mask;
		end
	end

	// join bits; software changes them with both channels off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_r <= RST_CONTROL;
		end else if (wr_en && idx == IDX_CONTROL) begin
			control_r <= wdat & join_mask;
		end
	end

	// scaled clock dividers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scale_a_r <= RST_SCALE;
			scale_b_r <= RST_SCALE;
		end else if (wr_en && idx == IDX_SCALE_A) begin
			scale_a_r <= wdat;
		end else if (wr_en && idx == IDX_SCALE_B) begin
			scale_b_r <= wdat;
		end
	end

	// per-channel period and duty bytes
	genvar r;
	generate
		for (r = 0; r < 8; r++) begin : g_chreg
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					period_r[r] <= RST_PERIOD;
					duty_r[r]   <= RST_DUTY;
				end else if (wr_en && chan_mask[r]) begin
					if (idx == IDX_PERIOD0 + 6'(r)) begin
						period_r[r] <= wdat;
					end
					if (idx == IDX_DUTY0 + 6'(r)) begin
						duty_r[r] <= wdat;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// unmapped or absent locations read zero
	always_comb begin
		rd_mux = 8'h00;
		case (idx)
			IDX_ENABLE:   rd_mux = enable_r;
			IDX_POLARITY: rd_mux = polarity_r;
			IDX_CLK_SEL:  rd_mux = clk_sel_r;
			IDX_PRESCALE: rd_mux = prescale_r;
			IDX_ALIGN:    rd_mux = align_r;
			IDX_CONTROL:  rd_mux = control_r;
			IDX_AB_SEL:   rd_mux = ab_sel_r;
			IDX_SCALE_A:  rd_mux = scale_a_r;
			IDX_SCALE_B:  rd_mux = scale_b_r;
			default: begin
				for (int k = 0; k < 8; k++) begin
					if (idx == IDX_PERIOD0 + 6'(k) && chan_mask[k]) begin
						rd_mux = period_r[k];
					end
					if (idx == IDX_DUTY0 + 6'(k) && chan_mask[k]) begin
						rd_mux = duty_r[k];
					end
				end
			end
		endcase
	end

	// read data captured at the edge that raises ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 8'h00;
		end else if (access) begin
			rdata_r <= we_i ? 8'h00 : rd_mux;
		end
	end

	assign dat_o = {24'h000000, rdata_r};

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	assign first_prescale_field  = prescale_r[FIRST_PRE_LSB +: 3];
	assign second_prescale_field = prescale_r[SECOND_PRE_LSB +: 3];

	// low-bit masks give divide by 1 to 128
	assign mask_a8 = (8'h01 << first_prescale_field) - 8'h01;
	assign mask_b8 = (8'h01 << second_prescale_field) - 8'h01;
	assign tick_a  = &(pre_cnt_r | ~mask_a8[6:0]);
	assign tick_b  = &(pre_cnt_r | ~mask_b8[6:0]);

	// free-running count, held at zero while every channel is off
	always_ff @(posedge clk_i) begin
		if (rst_i || enable_r == 8'h00) begin
			pre_cnt_r <= 7'h00;
		end else begin
			pre_cnt_r <= pre_cnt_r + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// scaled clocks: one tick every (divider + 1) prescaled ticks
	// ----------------------------------------------------------------
	assign tick_sa = tick_a && (sa_cnt_r >= scale_a_r);
	assign tick_sb = tick_b && (sb_cnt_r >= scale_b_r);

	always_ff @(posedge clk_i) begin
		if (rst_i || enable_r == 8'h00) begin
			sa_cnt_r <= 8'h00;
		end else if (tick_sa) begin
			sa_cnt_r <= 8'h00;
		end else if (tick_a) begin
			sa_cnt_r <= sa_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || enable_r == 8'h00) begin
			sb_cnt_r <= 8'h00;
		end else if (tick_sb) begin
			sb_cnt_r <= 8'h00;
		end else if (tick_b) begin
			sb_cnt_r <= sb_cnt_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < 8; c++) begin : g_ch
			logic        ch_tick;
			logic        ch_en;
			logic        joined;
			logic [15:0] ch_period;
			logic [15:0] ch_duty;
			logic [1:0]  src;

			assign src = {ab_sel_r[c], clk_sel_r[c]};

			// channel groups differ only in which clock is their own
			if ((c % 4) < 2) begin : g_grp_a
				always_comb begin
					case (src)
						SRC_PRE_OWN:    ch_tick = tick_a;
						SRC_SCALED_OWN: ch_tick = tick_sa;
						SRC_PRE_ALT:    ch_tick = tick_b;
						SRC_SCALED_ALT: ch_tick = tick_sb;
						default:        ch_tick = tick_a;
					endcase
				end
			end else begin : g_grp_b
				always_comb begin
					case (src)
						SRC_PRE_OWN:    ch_tick = tick_b;
						SRC_SCALED_OWN: ch_tick = tick_sb;
						SRC_PRE_ALT:    ch_tick = tick_a;
						SRC_SCALED_ALT: ch_tick = tick_sa;
						default:        ch_tick = tick_b;
					endcase
				end
			end

			assign joined = control_r[JOIN_LSB + c / 2];

			if (c % 2 == 1) begin : g_odd
				// joined pair: even bytes high, odd bytes low
				assign ch_period = joined ? {period_r[c - 1], period_r[c]}
				                          : {8'h00, period_r[c]};
				assign ch_duty   = joined ? {duty_r[c - 1], duty_r[c]}
				                          : {8'h00, duty_r[c]};
				assign ch_en     = enable_r[c];
			end else begin : g_even
				// even pin and enable drop out while joined
				assign ch_period = {8'h00, period_r[c]};
				assign ch_duty   = {8'h00, duty_r[c]};
				assign ch_en     = enable_r[c] & ~joined;
			end

			pcc_channel u_channel (
				.clk_i    (clk_i),
				.rst_i    (rst_i),
				.tick_i   (ch_tick),
				.en_i     (ch_en & chan_mask[c]),
				.pol_i    (polarity_r[c]),
				.center_i (align_r[c]),
				.period_i (ch_period),
				.duty_i   (ch_duty),
				.wave_o   (wave[c])
			);
		end
	endgenerate

	// pin outputs; absent channels stay low
	assign pwm_o = wave & chan_mask;

endmodule

// *** pcc_pkg.sv ***
package pcc_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_ENABLE   = 6'h00;
	localparam logic [5:0] IDX_POLARITY = 6'h01;
	localparam logic [5:0] IDX_CLK_SEL  = 6'h02;
	localparam logic [5:0] IDX_PRESCALE = 6'h03;
	localparam logic [5:0] IDX_ALIGN    = 6'h04;
	localparam logic [5:0] IDX_CONTROL  = 6'h05;
	localparam logic [5:0] IDX_AB_SEL   = 6'h06;
	localparam logic [5:0] IDX_SCALE_A  = 6'h08;
	localparam logic [5:0] IDX_SCALE_B  = 6'h09;
	localparam logic [5:0] IDX_PERIOD0  = 6'h14;
	localparam logic [5:0] IDX_DUTY0    = 6'h1c;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int         FIRST_PRE_LSB  = 0;
	localparam int         SECOND_PRE_LSB = 4;
	localparam int         JOIN_LSB       = 4;
	localparam logic [7:0] PRESCALE_MASK  = 8'h77;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ENABLE   = 8'h00;
	localparam logic [7:0] RST_POLARITY = 8'h00;
	localparam logic [7:0] RST_CLK_SEL  = 8'h00;
	localparam logic [7:0] RST_PRESCALE = 8'h00;
	localparam logic [7:0] RST_ALIGN    = 8'h00;
	localparam logic [7:0] RST_CONTROL  = 8'h00;
	localparam logic [7:0] RST_AB_SEL   = 8'h00;
	localparam logic [7:0] RST_SCALE    = 8'h00;
	localparam logic [7:0] RST_PERIOD   = 8'hff;
	localparam logic [7:0] RST_DUTY     = 8'h00;

	// ----------------------------------------------------------------
	// clock source codes {ab_select_bit, scaled_select_bit}
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_PRE_OWN    = 2'h0;
	localparam logic [1:0] SRC_SCALED_OWN = 2'h1;
	localparam logic [1:0] SRC_PRE_ALT    = 2'h2;
	localparam logic [1:0] SRC_SCALED_ALT = 2'h3;

	// channel counter phase
	typedef enum logic [1:0] {PH_IDLE, PH_UP, PH_DOWN} pcc_phase_t;

endpackage

// *** pcc_channel.sv ***
`timescale 1ns/100ps

// one waveform channel: counter, duty compare and output level
module pcc_channel (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        tick_i,
	input  wire logic        en_i,
	input  wire logic        pol_i,
	input  wire logic        center_i,
	input  wire logic [15:0] period_i,
	input  wire logic [15:0] duty_i,
	output logic             wave_o
);
	import pcc_pkg::*;

	pcc_phase_t  phase_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_inc;

	assign cnt_inc = cnt_r + 16'h0001;

	// ----------------------------------------------------------------
	// counter sequencing
	// ----------------------------------------------------------------
	// start waits for the selected source's next tick
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			phase_r <= PH_IDLE;
			cnt_r   <= 16'h0000;
		end else if (tick_i) begin
			case (phase_r)
				PH_IDLE: begin
					phase_r <= PH_UP;
					cnt_r   <= 16'h0000;
				end
				PH_UP: begin
					if (period_i == 16'h0000) begin
						cnt_r <= 16'h0000;
					end else if (!center_i) begin
						// left aligned: wrap at period
						cnt_r <= (cnt_inc >= period_i) ? 16'h0000 : cnt_inc;
					end else if (cnt_r >= period_i) begin
						// center aligned: turn at period
						phase_r <= PH_DOWN;
						cnt_r   <= cnt_r - 16'h0001;
					end else begin
						cnt_r <= cnt_inc;
					end
				end
				PH_DOWN: begin
					if (cnt_r == 16'h0000 || !center_i) begin
						phase_r <= PH_UP;
						cnt_r   <= cnt_inc;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				default: begin
					phase_r <= PH_IDLE;
					cnt_r   <= 16'h0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// output level
	// ----------------------------------------------------------------
	// polarity level until duty match, opposite level after
	always_ff @(posedge clk_i) begin
		if (rst_i || phase_r == PH_IDLE) begin
			wave_o <= 1'b0;
		end else if (cnt_r < duty_i) begin
			wave_o <= pol_i;
		end else begin
			wave_o <= ~pol_i;
		end
	end

endmodule

// *** pcc_pwm_config_asserts.sv ***
`timescale 1ns/100ps

// watches bus answers and pin levels of the config block
module pcc_pwm_config_asserts
	import pcc_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        we_i,
	input wire logic [3:0]  sel_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [7:0]  pwm_o
);
	localparam logic [7:0] CH_M = 8'((1 << NUM_CH) - 1);
	localparam logic [3:0] JN_M = 4'((1 << (NUM_CH / 2)) - 1);
	logic       take;
	logic       rd;
	logic [7:0] ev;
	logic [7:0] en_r;
	logic [7:0] pol_r;
	logic [7:0] pre_r;
	logic [3:0] jn_r;

	// taken request, taken read, even pins of joined pairs
	assign take = cyc_i && stb_i && !ack_o;
	assign rd   = take && !we_i;
	assign ev   = {1'b0, jn_r[3], 1'b0, jn_r[2], 1'b0, jn_r[1], 1'b0, jn_r[0]};

	// shadow copies of the registers that steer the checks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r <= 8'h00;
			pol_r <= 8'h00;
			pre_r <= 8'h00;
			jn_r <= 4'h0;
		end else if (take && we_i && sel_i[0]) begin
			if (adr_i[7:2] == IDX_ENABLE) en_r <= dat_i[7:0] & CH_M;
			if (adr_i[7:2] == IDX_POLARITY) pol_r <= dat_i[7:0] & CH_M;
			if (adr_i[7:2] == IDX_PRESCALE) pre_r <= dat_i[7:0] & PRESCALE_MASK;
			if (adr_i[7:2] == IDX_CONTROL) jn_r <= dat_i[7:4] & JN_M;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack_pulse;
		take |=> ack_o ##1 !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a one-cycle answer");
	property p_upper_zero;
		ack_o |-> dat_o[31:8] == 24'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits set");
	property p_reset_quiet;
		$fell(rst_i) |-> !ack_o && pwm_o == 8'h00;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
	property p_pol_read;
		rd && adr_i[7:2] == IDX_POLARITY |=> dat_o == {24'h0, pol_r};
	endproperty
	a_pol_read: assert property (p_pol_read) else $error("polarity readback wrong");
	property p_pre_read;
		rd && adr_i[7:2] == IDX_PRESCALE |=> dat_o == {24'h0, pre_r};
	endproperty
	a_pre_read: assert property (p_pre_read) else $error("prescale readback wrong");
	property p_join_read;
		rd && adr_i[7:2] == IDX_CONTROL |=> dat_o == {24'h0, jn_r, 4'h0};
	endproperty
	a_join_read: assert property (p_join_read) else $error("join readback wrong");
	property p_even_off;
		(|jn_r) |-> (pwm_o & ev & $past(ev)) == 8'h00;
	endproperty
	a_even_off: assert property (p_even_off) else $error("joined even pin active");
	property p_off_low;
		(pwm_o & ~(en_r | $past(en_r) | $past(en_r, 2))) == 8'h00;
	endproperty
	a_off_low: assert property (p_off_low) else $error("disabled pin active");
endmodule

bind pcc_pwm_config pcc_pwm_config_asserts #(.NUM_CH(NUM_CH)) u_asserts (
	.clk_i (clk_i),
	.rst_i (rst_i),
	.adr_i (adr_i),
	.dat_i (dat_i),
	.dat_o (dat_o),
	.we_i  (we_i),
	.sel_i (sel_i),
	.cyc_i (cyc_i),
	.stb_i (stb_i),
	.ack_o (ack_o),
	.pwm_o (pwm_o)
);

// *** pcc_pwm_config_tb.sv ***
`timescale 1ns/100ps

// drives the register bus and measures the channel pins
module pcc_pwm_config_tb;
	import pcc_pkg::*;
	localparam int TB_CH = 6;
	logic        clk_i;
	logic        rst_i;
	logic [7:0]  adr_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        we_i;
	logic [3:0]  sel_i;
	logic        cyc_i;
	logic        stb_i;
	logic        ack_o;
	logic [7:0]  pwm_o;
	logic [31:0] rd;
	int          failures;
	int          checked;
	int          rises;
	int          highs;
	logic [5:0]  cfg_idx [6] = '{IDX_POLARITY, IDX_CLK_SEL, IDX_ALIGN, IDX_AB_SEL,
		IDX_PRESCALE, IDX_CONTROL};
	logic [7:0]  cfg_exp [6] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h77, 8'h70};
	int          src_rises [4] = '{24, 12, 6, 2};

	pcc_pwm_config #(.NUM_CH(TB_CH)) dut (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.adr_i (adr_i),
		.dat_i (dat_i),
		.dat_o (dat_o),
		.we_i  (we_i),
		.sel_i (sel_i),
		.cyc_i (cyc_i),
		.stb_i (stb_i),
		.ack_o (ack_o),
		.pwm_o (pwm_o)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] wd,
		input logic s0);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h0, wd};
		sel_i <= {3'b000, s0};
		// only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] v);
		bus(idx, 1'b1, v, 1'b1);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
		bus(idx, 1'b0, 8'h00, 1'b1);
		check(rd, exp);
	endtask

	// counts rising edges and high samples of one pin
	task automatic measure(input int ch, input int w);
		logic prev;
		rises = 0;
		highs = 0;
		@(posedge clk_i);
		#1 prev = pwm_o[ch];
		repeat (w) begin
			@(posedge clk_i);
			#1;
			if (pwm_o[ch] === 1'b1 && prev !== 1'b1) rises++;
			if (pwm_o[ch] === 1'b1) highs++;
			prev = pwm_o[ch];
		end
	endtask

	task automatic report_and_stop();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		#200000;
		failures++;
		report_and_stop();
	end

	initial begin
		failures = 0;
		checked = 0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		dat_i = 32'h0;
		sel_i = 4'h1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values and an unmapped index
		for (int k = 0; k < 10; k++) rd_chk(6'(k), 32'h0);
		rd_chk(IDX_PERIOD0, 32'hff);
		rd_chk(6'h30, 32'h0);
		$display("test reset done");
		// bits of absent channels and reserved fields
		foreach (cfg_idx[i]) begin
			wr(cfg_idx[i], 8'hff);
			rd_chk(cfg_idx[i], {24'h0, cfg_exp[i]});
		end
		bus(IDX_POLARITY, 1'b1, 8'h00, 1'b0);
		rd_chk(IDX_POLARITY, 32'h3f);
		foreach (cfg_idx[i]) wr(cfg_idx[i], 8'h00);
		$display("test masks done");
		// polarity turned round while channel 0 runs
		wr(IDX_PERIOD0, 8'h04);
		wr(IDX_DUTY0, 8'h01);
		wr(IDX_ENABLE, 8'h01);
		for (int p = 1; p >= 0; p--) begin
			wr(IDX_POLARITY, 8'(p));
			repeat (20) @(posedge clk_i);
			measure(0, 16);
			check(32'(highs), p ? 32'd4 : 32'd12);
			check(32'(rises), 32'd4);
		end
		$display("test polarity done");
		// every source code on a channel of each group
		wr(IDX_ENABLE, 8'h00);
		wr(IDX_PRESCALE, 8'h20);
		wr(IDX_SCALE_A, 8'h01);
		wr(IDX_SCALE_B, 8'h02);
		for (int c = 0; c <= 2; c += 2) begin
			wr(IDX_PERIOD0 + 6'(c), 8'h02);
			wr(IDX_DUTY0 + 6'(c), 8'h01);
			wr(IDX_ENABLE, 8'(1 << c));
			for (int s = 0; s < 4; s++) begin
				wr(IDX_CLK_SEL, 8'((s & 1) << c));
				wr(IDX_AB_SEL, 8'((s >> 1) << c));
				repeat (60) @(posedge clk_i);
				measure(c, 48);
				check(32'(rises), 32'(src_rises[c == 2 ? s ^ 2 : s]));
			end
			wr(IDX_ENABLE, 8'h00);
		end
		wr(IDX_CLK_SEL, 8'h00);
		wr(IDX_AB_SEL, 8'h00);
		wr(IDX_PRESCALE, 8'h00);
		$display("test clock select done");
		// center then left alignment, changed while disabled
		wr(IDX_PERIOD0, 8'h04);
		wr(IDX_DUTY0, 8'h02);
		for (int a = 1; a >= 0; a--) begin
			wr(IDX_ENABLE, 8'h00);
			wr(IDX_ALIGN, 8'(a));
			wr(IDX_ENABLE, 8'h01);
			repeat (20) @(posedge clk_i);
			measure(0, 64);
			check(32'(rises), a ? 32'd8 : 32'd16);
		end
		$display("test alignment done");
		// channels 0 and 1 joined into one 16-bit channel
		wr(IDX_ENABLE, 8'h00);
		wr(IDX_CONTROL, 8'h10);
		wr(IDX_PERIOD0, 8'h01);
		wr(IDX_PERIOD0 + 6'd1, 8'h00);
		wr(IDX_DUTY0, 8'h00);
		wr(IDX_DUTY0 + 6'd1, 8'h40);
		wr(IDX_POLARITY, 8'h02);
		wr(IDX_ENABLE, 8'h03);
		repeat (300) @(posedge clk_i);
		measure(1, 512);
		check(32'(rises), 32'd2);
		check(32'(highs), 32'd128);
		measure(0, 64);
		check(32'(highs), 32'd0);
		check(32'(pwm_o[7:6]), 32'h0);
		$display("test join done");
		report_and_stop();
	end
endmodule
